// File: verilog/sbs_sram_control.sv
// Synchronous burst SRAM: cycle decode, burst addressing, byte writes and data drivers.
// Assumes all inputs are synchronous to mclk; out_en_n acts on the drivers directly.
//
// Contract
// - Linear order adds beat count modulo four.
// - Interleaved order XORs start with beat count.
// - Fifth beat returns to the loaded start.
// - Deselect on unselected start; data high-Z.
// - Selected processor strobe begins a read burst.
// - Controller strobe loads address; write or read.
// - No strobe, advance low: next address.
// - No strobe, advance high: repeat current address.
// - Write when global write or gated lane.
// - Global write stores every byte lane.
// - Gated byte write stores only enabled lanes.
// - Reads drive all lanes regardless of enables.
// - Writes keep all lanes high impedance.
// - Output enable high disables drivers at once.
// - Output enable low never starts drivers itself.
// - Dummy reads advance the counter like reads.
// - Order select low linear, high interleaved.
// - Output select low flow-through, high pipelined.
// - Low address bits preset counter on load.
// - Sleep high gives standby, contents kept.
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_control
  import sbs_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_W_DEF
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_sel_primary_n,
  input  wire logic              chip_sel_high,
  input  wire logic              chip_sel_low_n,
  input  wire logic              cpu_addr_load_n,
  input  wire logic              ctl_addr_load_n,
  input  wire logic              burst_step_n,
  input  wire logic              all_bytes_wr_n,
  input  wire logic              lane_wr_gate_n,
  input  wire logic              byte_en_a_n,
  input  wire logic              byte_en_b_n,
  input  wire logic              byte_en_c_n,
  input  wire logic              byte_en_d_n,
  input  wire logic              out_en_n,
  input  wire logic              linear_order_n,
  input  wire logic              flow_through_sel_n,
  input  wire logic              sleep_req,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output sbs_op_type             cycle_kind,
  output logic      [ADDR_W-1:0] cycle_addr,
  output logic                   standby
);
  localparam int unsigned DEPTH = 1 << ADDR_W;

  // Three address bits is the least that leaves an upper part above the burst
  // counter; the cap keeps the modelled array a sensible size.
  initial begin
    if (ADDR_W < BURST_W + 1) begin
      $error("sbs_sram_control: ADDR_W must be at least 3");
    end
    if (ADDR_W > 20) begin
      $error("sbs_sram_control: ADDR_W must not exceed 20");
    end
  end

  // The array is never reset: its contents are unknown until first written.
  logic [DATA_W-1:0]        mem [0:DEPTH-1];
  logic [ADDR_W-1:BURST_W]  upper;
  logic [BURST_W-1:0]       cur_lo;
  logic [BURST_W-1:0]       next_lo;
  logic [LANES-1:0]         lane_en_n;
  logic [LANES-1:0]         lanes;
  logic                     wr_decode;
  logic                     sec_enable;
  sbs_op_type               next_op;
  sbs_addr_src_type         next_src;
  logic [ADDR_W-1:0]        next_addr;
  logic                     load_ext;
  logic                     step;
  logic [DATA_W-1:0]        ft_data;
  logic                     ft_drive;
  logic                     pl_drive;
  logic                     wr_cycle;
  logic                     first_sel;
  logic                     cpu_start;
  logic                     ctl_start;
  logic                     rd_now;
  logic                     wr_now;

  // Lane write mask; global write overrides the gate and the individual enables.
  function automatic logic [LANES-1:0] lane_mask(input logic             gw_n,
                                                 input logic             gate_n,
                                                 input logic [LANES-1:0] en_n);
    if (!gw_n) begin
      lane_mask = {LANES{1'b1}};
    end else if (!gate_n) begin
      lane_mask = ~en_n;
    end else begin
      lane_mask = {LANES{1'b0}};
    end
  endfunction

  // Read or write, once a cycle is known to touch the array.
  function automatic sbs_op_type rw_op(input logic wr);
    if (wr) begin
      rw_op = SBS_WRITE;
    end else begin
      rw_op = SBS_READ;
    end
  endfunction

  // Lane a is the lowest nine data bits, lane d the highest.
  assign lane_en_n  = {byte_en_d_n, byte_en_c_n, byte_en_b_n, byte_en_a_n};
  assign lanes      = lane_mask(all_bytes_wr_n, lane_wr_gate_n, lane_en_n);
  assign wr_decode  = |lanes;
  assign sec_enable = chip_sel_high & ~chip_sel_low_n;
  // Named start terms keep the priority chain below close to the cycle table.
  assign first_sel  = ~chip_sel_primary_n;
  assign cpu_start  = first_sel & ~cpu_addr_load_n;
  assign ctl_start  = ~ctl_addr_load_n;

  // Cycle decode, evaluated from the values present at the rising edge. The
  // processor strobe counts only with the first select active, while the
  // controller strobe always starts a cycle, a deselect if the chip is unselected.
  always_comb begin
    next_op  = SBS_DESELECT;
    next_src = SBS_ADDR_NONE;
    if (sleep_req) begin
      // Standby blocks every access; the array is untouched so contents survive.
      // Sleep wins over both strobes, so a request during standby is dropped.
      next_op  = SBS_DESELECT;
      next_src = SBS_ADDR_NONE;
    end else if (cpu_start) begin
      if (sec_enable) begin
        next_op  = SBS_READ;
        next_src = SBS_ADDR_EXTERNAL;
      end else begin
        next_op  = SBS_DESELECT;
      end
    end else if (ctl_start) begin
      if (first_sel && sec_enable) begin
        next_op  = rw_op(wr_decode);
        next_src = SBS_ADDR_EXTERNAL;
      end else begin
        next_op  = SBS_DESELECT;
      end
    end else if (!burst_step_n) begin
      next_op  = rw_op(wr_decode);
      next_src = SBS_ADDR_NEXT;
    end else begin
      next_op  = rw_op(wr_decode);
      next_src = SBS_ADDR_CURRENT;
    end
  end

  // Either strobe that starts a selected cycle presets the counter and upper bits.
  assign load_ext = (next_src == SBS_ADDR_EXTERNAL);
  // The counter steps on any continue cycle, whether out_en_n lets data out or not.
  assign step     = (next_src == SBS_ADDR_NEXT);

  // Read and write strobes of the captured cycle, shared by the data paths.
  assign rd_now = (next_op == SBS_READ);
  assign wr_now = (next_op == SBS_WRITE);

  // Suspend and deselect keep the current address, so a later continue cycle
  // picks up where the burst stopped.
  always_comb begin
    next_addr = {upper, cur_lo};
    case (next_src)
      SBS_ADDR_EXTERNAL: next_addr = addr;
      SBS_ADDR_NEXT:     next_addr = {upper, next_lo};
      default:           next_addr = {upper, cur_lo};
    endcase
  end

  // Only the two low bits count; the upper part sits in its own register so a
  // burst never carries into it.
  sbs_burst_counter u_burst (
    .mclk       (mclk),
    .nrst       (nrst),
    .load       (load_ext),
    .advance    (step),
    .interleave (linear_order_n),
    .start_in   (addr[BURST_W-1:0]),
    .cur_lo     (cur_lo),
    .next_lo    (next_lo)
  );

  // Upper address bits are loaded with the start address and never counted.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      upper <= '0;
    end else if (load_ext) begin
      upper <= addr[ADDR_W-1:BURST_W];
    end
  end

  // Write data is taken on the same edge as the cycle that carries it. A lane
  // outside the mask keeps its old contents.
  always_ff @(posedge mclk) begin
    if (wr_now) begin
      for (int i = 0; i < LANES; i++) begin
        if (lanes[i]) begin
          mem[next_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Flow-through data is valid right after the capturing edge. It holds its word
  // between reads so that the pipelined stage can still pick it up.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ft_data <= '0;
    end else if (rd_now) begin
      ft_data <= mem[next_addr];
    end
  end

  // The output register doubles as the pipeline stage, so dq_out always comes
  // from a flop. The mode pin is meant to be static; changing it while reads are
  // in flight may show one word twice or skip one.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dq_out <= '0;
    end else if (flow_through_sel_n) begin
      dq_out <= ft_data;
    end else if (rd_now) begin
      dq_out <= mem[next_addr];
    end
  end

  // Driver requests: only read cycles raise them, and all lanes together.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ft_drive <= 1'b0;
    end else begin
      ft_drive <= rd_now;
    end
  end

  // The pipelined request trails the flow-through one by a clock, like its data.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pl_drive <= 1'b0;
    end else begin
      pl_drive <= ft_drive;
    end
  end

  // A captured write forces the drivers off even if pipelined read data is pending.
  // Flow-through reads cannot overlap a write, so this only matters when pipelined.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_cycle <= 1'b0;
    end else begin
      wr_cycle <= wr_now;
    end
  end

  // Status outputs report the cycle decoded at the last edge; they are for the
  // surrounding logic and tests, not part of the memory interface.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cycle_kind <= SBS_DESELECT;
    end else begin
      cycle_kind <= next_op;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cycle_addr <= '0;
    end else begin
      cycle_addr <= next_addr;
    end
  end

  // Standby follows the request by one clock, like the other status outputs.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      standby <= 1'b0;
    end else begin
      standby <= sleep_req;
    end
  end

  // The output enable gate is combinational: out_en_n must cut the drivers
  // without waiting for a clock, which no flip-flop could do.
  assign dq_oe  = (flow_through_sel_n ? pl_drive : ft_drive)
                  & ~wr_cycle
                  & ~out_en_n;
endmodule
`default_nettype wire

// File: verilog/sbs_pkg.sv
// Shared constants and types for the synchronous burst SRAM control block.
// Assumes a single 20 MHz clock; nothing here depends on the surrounding bus.
`default_nettype none
package sbs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LANES         = 4;
  localparam int unsigned LANE_W        = 9;
  localparam int unsigned DATA_W        = LANES * LANE_W;
  localparam int unsigned ADDR_W_DEF    = 10;
  localparam int unsigned BURST_W       = 2;
  localparam logic [1:0]  BURST_START   = 2'h0;
  localparam logic [1:0]  BURST_ONE     = 2'h1;

  // Kind of cycle captured at a rising edge.
  typedef enum logic [1:0] {
    SBS_DESELECT,
    SBS_READ,
    SBS_WRITE
  } sbs_op_type;

  // Where the address of a captured cycle comes from.
  typedef enum logic [1:0] {
    SBS_ADDR_NONE,
    SBS_ADDR_EXTERNAL,
    SBS_ADDR_NEXT,
    SBS_ADDR_CURRENT
  } sbs_addr_src_type;
endpackage
`default_nettype wire

// File: verilog/sbs_burst_counter.sv
// Two-bit burst address counter with linear or interleaved order.
// Assumes load and advance are already decoded and never both high.
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_counter
  import sbs_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               load,
  input  wire logic               advance,
  input  wire logic               interleave,
  input  wire logic [BURST_W-1:0] start_in,
  output logic      [BURST_W-1:0] cur_lo,
  output logic      [BURST_W-1:0] next_lo
);
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] beat;
  logic [BURST_W-1:0] beat_inc;

  function automatic logic [BURST_W-1:0] order_addr(input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic               ilv);
    logic [BURST_W-1:0] sum;
    sum = base + cnt;
    order_addr = ilv ? (base ^ cnt) : sum;
  endfunction

  // The beat count wraps modulo four, so the fifth beat repeats the start.
  assign beat_inc = beat + BURST_ONE;
  assign cur_lo   = order_addr(start, beat, interleave);
  assign next_lo  = order_addr(start, beat_inc, interleave);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start <= BURST_START;
      beat  <= BURST_START;
    end else if (load) begin
      start <= start_in;
      beat  <= BURST_START;
    end else if (advance) begin
      beat <= beat_inc;
    end
  end
endmodule
`default_nettype wire

// File: sim/sbs_sram_control_sva.sv
// Checker for the burst SRAM control: cycle decode, burst steps and driver gating.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_control_sva
  import sbs_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_W_DEF
) (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              chip_sel_primary_n,
  input wire logic              chip_sel_high,
  input wire logic              chip_sel_low_n,
  input wire logic              cpu_addr_load_n,
  input wire logic              ctl_addr_load_n,
  input wire logic              burst_step_n,
  input wire logic              all_bytes_wr_n,
  input wire logic              out_en_n,
  input wire logic              linear_order_n,
  input wire logic              flow_through_sel_n,
  input wire logic              sleep_req,
  input wire logic              dq_oe,
  input wire sbs_op_type        cycle_kind,
  input wire logic [ADDR_W-1:0] cycle_addr,
  input wire logic              standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic sel;
  logic idle;
  assign sel  = !sleep_req && !chip_sel_primary_n && chip_sel_high && !chip_sel_low_n;
  assign idle = !sleep_req && cpu_addr_load_n && ctl_addr_load_n;
  a_cpu_read_start: assert property (sel && !cpu_addr_load_n |=>
    cycle_kind == SBS_READ && cycle_addr == $past(addr)) else $error("cpu read start");
  a_ctl_write_start: assert property (sel && cpu_addr_load_n && !ctl_addr_load_n
    && !all_bytes_wr_n |=> cycle_kind == SBS_WRITE && cycle_addr == $past(addr))
    else $error("controller write start");
  a_unsel_deselect: assert property (!sleep_req && chip_sel_primary_n &&
    !ctl_addr_load_n |=> cycle_kind == SBS_DESELECT) else $error("no deselect");
  a_write_quiet: assert property (cycle_kind == SBS_WRITE |-> !dq_oe)
    else $error("driving during write");
  a_oe_blocks: assert property (out_en_n |-> !dq_oe)
    else $error("driving with output enable high");
  a_ft_read_drive: assert property (!flow_through_sel_n && !out_en_n &&
    cycle_kind == SBS_READ |-> dq_oe) else $error("read not driven");
  a_ft_desel_off: assert property (!flow_through_sel_n &&
    cycle_kind == SBS_DESELECT |-> !dq_oe) else $error("driving when deselected");
  a_suspend_hold: assert property (idle && burst_step_n |=> $stable(cycle_addr))
    else $error("suspend moved address");
  a_linear_step: assert property (idle && !burst_step_n && !linear_order_n |=>
    cycle_addr[1:0] == $past(cycle_addr[1:0]) + 2'h1) else $error("bad linear step");
  a_sleep_standby: assert property (sleep_req |=>
    standby && cycle_kind == SBS_DESELECT) else $error("sleep not honoured");
  c_read_drive: cover property (dq_oe && cycle_kind == SBS_READ);
  c_write: cover property (cycle_kind == SBS_WRITE);
  c_standby: cover property (standby);
endmodule
bind sbs_sram_control sbs_sram_control_sva #(.ADDR_W(ADDR_W)) i_sva (
  .mclk, .nrst, .addr, .chip_sel_primary_n, .chip_sel_high, .chip_sel_low_n,
  .cpu_addr_load_n, .ctl_addr_load_n, .burst_step_n, .all_bytes_wr_n, .out_en_n,
  .linear_order_n, .flow_through_sel_n, .sleep_req, .dq_oe, .cycle_kind, .cycle_addr,
  .standby
);
`default_nettype wire

// File: sim/sbs_host_model.sv
// Host controller model driving strobes, selects, mode pins and write data.
// Assumes one cyc call per clock; each call returns just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model
  import sbs_pkg::*;
(
  input  wire logic              mclk,
  output logic      [8:0]        ctl,
  output logic      [3:0]        adr,
  output logic      [5:0]        wr,
  output logic      [DATA_W-1:0] wd
);
  initial begin
    ctl = 9'h01f;
    adr = 4'h0;
    wr  = 6'h3f;
    wd  = '0;
  end
  task automatic cyc(input logic [8:0] c, input logic [3:0] a, input logic [5:0] w,
                     input logic [DATA_W-1:0] d);
    @(negedge mclk);
    ctl = c;
    adr = a;
    wr  = w;
    // Unless a write strobe is low the data lines toggle, so a stale value can never look valid.
    wd  = (w[5] && w[4]) ? ~wd : d;
    @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the burst SRAM control block.
// Assumes the host model drives every input but mclk and nrst; a shadow array predicts read data.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import sbs_pkg::*;
;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic [8:0]        ctl;
  logic [3:0]        adr;
  logic [5:0]        wr;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] dq_out;
  logic              dq_oe;
  sbs_op_type        cycle_kind;
  logic [3:0]        cycle_addr;
  logic              standby;
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] nd;
  logic [8:0]        dsl [4] = '{9'h01d, 9'h003, 9'h005, 9'h113};
  int                failures = 0;
  int                cmp_count = 0;
  sbs_host_model i_host (.mclk, .ctl, .adr, .wr, .wd);
  sbs_sram_control #(.ADDR_W(4)) i_dut (
    .mclk, .nrst, .addr(adr), .chip_sel_primary_n(ctl[3]), .chip_sel_high(ctl[4]),
    .chip_sel_low_n(~ctl[4]), .cpu_addr_load_n(ctl[2]), .ctl_addr_load_n(ctl[1]),
    .burst_step_n(ctl[0]), .all_bytes_wr_n(wr[5]), .lane_wr_gate_n(wr[4]),
    .byte_en_a_n(wr[0]), .byte_en_b_n(wr[1]), .byte_en_c_n(wr[2]), .byte_en_d_n(wr[3]),
    .out_en_n(ctl[5]), .linear_order_n(ctl[6]), .flow_through_sel_n(ctl[7]),
    .sleep_req(ctl[8]), .dq_in(wd), .dq_out, .dq_oe, .cycle_kind, .cycle_addr, .standby);
  always #25 mclk = ~mclk;
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic burst(input logic [8:0] md, input logic [8:0] st, input logic [3:0] a);
    logic [1:0] lo;
    for (int b = 0; b < 6; b++) begin
      i_host.cyc(md | ((b == 0) ? st : 9'h016), a, 6'h3f, '0);
      lo = md[6] ? (a[1:0] ^ 2'(b)) : (a[1:0] + 2'(b));
      `CHK(cycle_addr, {a[3:2], lo})
      `CHK(dq_oe, !md[5])
      if (!md[5]) `CHK(dq_out, mem[{a[3:2], lo}])
    end
  endtask
  // The run needs under a hundred cycles, so a 100 us limit only trips on a hang.
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 16; i++) begin
      mem[i] = {4{9'(i)}} ^ 36'h5a5a5a5a5;
      i_host.cyc(9'h015, 4'(i), 6'h1f, mem[i]);
      `CHK(cycle_kind, SBS_WRITE)
      `CHK(dq_oe, 1'b0)
    end
    burst(9'h000, 9'h013, 4'h5);
    i_host.cyc(9'h017, 4'h0, 6'h3f, '0);
    `CHK(cycle_addr, 4'h6)
    burst(9'h040, 9'h014, 4'ha);
    burst(9'h020, 9'h013, 4'h7);
    for (int m = 0; m < 16; m++) begin
      nd = mem[3];
      for (int l = 0; l < 4; l++) begin
        if (!m[l]) nd[9*l+:9] = ~nd[9*l+:9];
      end
      i_host.cyc(9'h035, 4'h3, 6'(6'h20 | m), ~mem[3]);
      `CHK(cycle_kind, (m == 15) ? SBS_READ : SBS_WRITE)
      `CHK(dq_oe, 1'b0)
      mem[3] = nd;
      i_host.cyc(9'h013, 4'h3, 6'h3f, '0);
      `CHK(dq_out, mem[3])
    end
    for (int i = 0; i < 4; i++) begin
      i_host.cyc(dsl[i], 4'h0, 6'h3f, '0);
      `CHK(cycle_kind, SBS_DESELECT)
      `CHK(dq_oe, 1'b0)
      `CHK(standby, 1'(i == 3))
    end
    i_host.cyc(9'h093, 4'h9, 6'h3f, '0);
    `CHK(dq_oe, 1'b0)
    i_host.cyc(9'h09d, 4'h0, 6'h3f, '0);
    `CHK(dq_oe, 1'b1)
    `CHK(dq_out, mem[9])
    wrap_up();
  end
endmodule
`default_nettype wire
